// *** pkg/spi_legacy_pkg.sv ***
// Constants and types for the plain SPI master block.
// Assumes a single 100 MHz clock domain and synchronous active-low reset.
package spi_legacy_pkg;
    localparam int          WORD_BITS      = 8;
    localparam int          CLK_DIV_W      = 8;
    localparam int          DLY_W          = 8;
    localparam logic [7:0]  CLK_DIV_RST    = 8'h02;
    localparam logic [7:0]  WORD_RST       = 8'h00;
    localparam logic [3:0]  BIT_LAST       = 4'h7;
    localparam logic [3:0]  BIT_RST        = 4'h0;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_DELAY = 2'b10
    } spi_state_t;
endpackage : spi_legacy_pkg

// *** hdl/spi_master_legacy_mode.sv ***
// Plain SPI master: transmit holding word, two-entry receive buffer, one shifter.
// Assumes all inputs synchronous to mclk_i; one slave on the bus.
//
// Overview of operation
// - Serial clock comes from internal baud divider; shifting follows it.
// - Block drives slave select and serial clock, owning every transfer.
// - One transmit holding word, a two-entry receive buffer, one shifter.
// - When idle and memory mode is off, a transmit write loads the shifter one clock later and starts the transfer.
// - MISO samples into the shifter as MOSI shifts out; full duplex.
// - Writes mid-transfer wait; at end receive moves, pending word starts.
// - Transmit-empty sets on move to shifter, clears on new write.
// - Transmit-empty flag is the transmit DMA request.
// - Idle flag marks end of transfers, after the programmed delay.
// - Receive-full sets on move into receive buffer, clears when it is read empty.
// - Inter-transfer delay idles between words; ignored in memory mode.
`timescale 1ns/1ps
`default_nettype none
module spi_master_legacy_mode
    import spi_legacy_pkg::*;
#(
    parameter int W = WORD_BITS
) (
    input  wire logic             mclk_i,
    input  wire logic             reset_n_i,
    input  wire logic             enable_i,
    input  wire logic             memory_mode_select_i,
    input  wire logic [7:0]       clk_div_i,
    input  wire logic [7:0]       inter_transfer_delay_i,
    input  wire logic             tx_valid_i,
    input  wire logic [W-1:0]     tx_data_i,
    output logic                  tx_ready_o,
    output logic                  rx_valid_o,
    output logic [W-1:0]          rx_data_o,
    input  wire logic             rx_ready_i,
    output logic                  tx_holding_empty_o,
    output logic                  transmitter_idle_o,
    output logic                  rx_holding_full_o,
    output logic                  slave_select_out_n_o,
    output logic                  serial_clock_out_o,
    output logic                  mosi_o,
    input  wire logic             miso_i
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    spi_state_t     state_q;
    logic [W-1:0]   tx_hold_q;
    logic [W-1:0]   shift_q;
    logic [W-1:0]   rx_buf_q [2];
    logic           rx_wp_q;
    logic           rx_rp_q;
    logic [1:0]     rx_cnt_q;
    logic [7:0]     div_q;
    logic [3:0]     bit_q;
    logic [7:0]     dly_q;
    logic           sck_q;
    logic           tx_holding_empty_q;

    logic tx_wr;
    logic baud_tick;
    logic word_done;
    logic load_shift;
    logic rx_push;
    logic rx_pop;
    logic [7:0] dly_eff;

    assign tx_wr      = tx_valid_i && tx_ready_o;
    assign baud_tick  = (state_q == ST_SHIFT) && (div_q == 8'h00);
    assign word_done  = baud_tick && sck_q && (bit_q == BIT_LAST);
    assign dly_eff    = memory_mode_select_i ? 8'h00
                                             : inter_transfer_delay_i;
    // Load when idle with a word, or right at word end when no delay applies
    assign load_shift = !tx_holding_empty_q && enable_i && !memory_mode_select_i &&
                        ((state_q == ST_IDLE) ||
                         (word_done && dly_eff == 8'h00));
    assign rx_push    = word_done;
    assign rx_pop     = rx_valid_o && rx_ready_i;

    // Transmit holding register accepts only while empty
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
            tx_hold_q <= WORD_RST;
        else if (tx_wr)
            tx_hold_q <= tx_data_i;
    end

    // Holding-empty flag; the move sets it, a write clears it
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
            tx_holding_empty_q <= 1'b1;
        else if (load_shift)
            tx_holding_empty_q <= 1'b1;
        else if (tx_wr)
            tx_holding_empty_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
        begin
            state_q <= ST_IDLE;
            dly_q   <= 8'h00;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                    if (load_shift)
                        state_q <= ST_SHIFT;
                ST_SHIFT:
                    if (word_done)
                    begin
                        if (dly_eff != 8'h00)
                        begin
                            state_q <= ST_DELAY;
                            dly_q   <= dly_eff;
                        end
                        else if (!load_shift)
                            state_q <= ST_IDLE;
                    end
                ST_DELAY:
                    if (dly_q == 8'h01)
                        state_q <= ST_IDLE;
                    else
                        dly_q <= dly_q - 8'h01;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // Baud divider and serial clock, mode 0 (idle low, sample on rise)
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i || state_q != ST_SHIFT)
        begin
            div_q <= CLK_DIV_RST;
            sck_q <= 1'b0;
            bit_q <= BIT_RST;
        end
        else if (baud_tick)
        begin
            div_q <= (clk_div_i == 8'h00) ? 8'h00 : clk_div_i - 8'h01;
            sck_q <= !sck_q;
            if (sck_q)
                bit_q <= (bit_q == BIT_LAST) ? BIT_RST : bit_q + 4'h1;
        end
        else
            div_q <= div_q - 8'h01;
    end

    // Shared shifter: captures MISO and advances on the rising clock edge;
    // the MOSI pin picks up the new top bit on the following falling edge
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
            shift_q <= WORD_RST;
        else if (load_shift)
            shift_q <= tx_hold_q;
        else if (baud_tick && !sck_q)
            shift_q <= {shift_q[W-2:0], miso_i};
    end

    // ------------------------------------------------------------
    // Two-entry receive buffer
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
        begin
            rx_wp_q  <= 1'b0;
            rx_rp_q  <= 1'b0;
            rx_cnt_q <= 2'd0;
        end
        else
        begin
            // Full buffer drops nothing in use: oldest word kept, newest lost
            if (rx_push && rx_cnt_q != 2'd2)
            begin
                rx_buf_q[rx_wp_q] <= shift_q;
                rx_wp_q           <= !rx_wp_q;
            end
            if (rx_pop)
                rx_rp_q <= !rx_rp_q;
            rx_cnt_q <= rx_cnt_q + {1'b0, rx_push && rx_cnt_q != 2'd2}
                                 - {1'b0, rx_pop};
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
        begin
            tx_ready_o           <= 1'b0;
            tx_holding_empty_o   <= 1'b0;
            transmitter_idle_o   <= 1'b0;
            rx_holding_full_o    <= 1'b0;
            rx_valid_o           <= 1'b0;
            rx_data_o            <= WORD_RST;
            slave_select_out_n_o <= 1'b1;
            serial_clock_out_o   <= 1'b0;
            mosi_o               <= 1'b0;
        end
        else
        begin
            tx_ready_o           <= enable_i && tx_holding_empty_q && !load_shift && !tx_wr;
            tx_holding_empty_o   <= enable_i && tx_holding_empty_q;
            transmitter_idle_o   <= enable_i && tx_holding_empty_q &&
                                    state_q == ST_IDLE && !load_shift;
            rx_holding_full_o    <= (rx_cnt_q != 2'd0);
            rx_valid_o           <= (rx_cnt_q != 2'd0) && !rx_pop;
            rx_data_o            <= rx_buf_q[rx_pop ? !rx_rp_q : rx_rp_q];
            slave_select_out_n_o <= !(state_q == ST_SHIFT || load_shift);
            // Clock pin takes the divider flop's next value, so the pin edge
            // falls on the same mclk edge as the sample or the data change
            serial_clock_out_o   <= (state_q == ST_SHIFT) &&
                                    (baud_tick ? !sck_q : sck_q);
            // Data moves only on a falling clock or at a load (mode 0)
            if (load_shift)
                mosi_o <= tx_hold_q[W-1];
            else if (baud_tick && sck_q)
                mosi_o <= shift_q[W-1];
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_tx_holding_empty_on_load: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        load_shift |=> tx_holding_empty_q) else $error("empty flag not set on load");
    a_tx_holding_empty_on_write: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        tx_wr && !load_shift |=> !tx_holding_empty_q) else $error("write left flag set");
    a_ss_low_shift: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        state_q == ST_SHIFT |=> !slave_select_out_n_o)
        else $error("select high mid word");
    a_idle_start: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        state_q == ST_IDLE && load_shift |=> state_q == ST_SHIFT)
        else $error("idle load did not start");
    a_dly_hold: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        state_q == ST_DELAY |-> !transmitter_idle_o)
        else $error("idle flag during delay");
    a_rx_full_push: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        rx_push |=> ##1 rx_holding_full_o) else $error("rx full not set");
    a_sck_idle: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        state_q == ST_IDLE && $past(state_q) == ST_IDLE |=> !serial_clock_out_o)
        else $error("clock toggles while idle");
    a_dma_req: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        tx_wr |=> ##1 !tx_holding_empty_o || $past(load_shift))
        else $error("request stays after write");
    a_mosi_hold: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        serial_clock_out_o |-> $stable(mosi_o))
        else $error("data moved while clock high");
endmodule : spi_master_legacy_mode
`default_nettype wire

// *** tb/spi_slave_model.sv ***
// Behavioural SPI slave, mode 0, one reply word per eight clocks.
// Assumes the master idles its clock low and selects active low.
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
    input  wire logic       sck_i,
    input  wire logic       ss_n_i,
    input  wire logic       mosi_i,
    input  wire logic [7:0] reply_i,
    output logic            miso_o,
    output logic [7:0]      got_o
);
    logic [7:0] sh_q;
    logic [2:0] cnt_q;
    initial
    begin
        miso_o = 1'b0;
        got_o  = 8'h00;
        cnt_q  = 3'h0;
    end
    // Present the reply as soon as selected
    always @(negedge ss_n_i)
    begin
        sh_q   = reply_i;
        miso_o = reply_i[7];
        cnt_q  = 3'h0;
    end
    // Capture the master's bit on the rising edge
    always @(posedge sck_i)
    begin
        got_o = {got_o[6:0], mosi_i};
        cnt_q = cnt_q + 3'h1;
    end
    // Next bit on the falling edge; reload after a whole word
    always @(negedge sck_i)
    begin
        sh_q   = (cnt_q == 3'h0) ? reply_i : {sh_q[6:0], 1'b0};
        miso_o = sh_q[7];
    end
    // A released line no longer shows its last level
    always @(posedge ss_n_i) miso_o = ~miso_o;
endmodule : spi_slave_model
`default_nettype wire

// *** tb/spi_master_legacy_mode_tb.sv ***
// Self-checking bench for the plain SPI master and a slave model.
// Assumes a 100 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module spi_master_legacy_mode_tb;
    import spi_legacy_pkg::*;
`define CHK(g, e) \
    begin \
        n_checks++; \
        if ((g) !== (e)) \
        begin \
            err_total++; \
            $display("FAIL %0t got %h exp %h", $time, g, e); \
        end \
    end
    typedef struct packed {logic [7:0] div, dly, tx, rep;} row_t;
    row_t       rows [4] = '{32'h01_00_a5_3c, 32'h00_05_80_01,
                             32'h03_14_01_fe, 32'h02_00_ff_00};
    logic       mclk = 1'b0;
    logic       rst_n = 1'b0;
    logic       en = 1'b1;
    logic       mms = 1'b0;
    logic [7:0] div = 8'h01;
    logic [7:0] dly = 8'h00;
    logic       tx_v = 1'b0;
    logic [7:0] tx_d = 8'h00;
    logic       rx_r = 1'b0;
    logic [7:0] rep = 8'h00;
    logic       tx_rdy, rx_v, txe, idle, rxf, ss_n, sck, mosi, miso;
    logic       sck_p, seen;
    logic [7:0] rx_d, got;
    int         err_total = 0;
    int         n_checks = 0;
    int         guard, rises, highs, gap;
    always #5 mclk = ~mclk;
    spi_master_legacy_mode uut (
        .mclk_i(mclk), .reset_n_i(rst_n), .enable_i(en),
        .memory_mode_select_i(mms), .clk_div_i(div),
        .inter_transfer_delay_i(dly), .tx_valid_i(tx_v), .tx_data_i(tx_d),
        .tx_ready_o(tx_rdy), .rx_valid_o(rx_v), .rx_data_o(rx_d),
        .rx_ready_i(rx_r), .tx_holding_empty_o(txe),
        .transmitter_idle_o(idle), .rx_holding_full_o(rxf),
        .slave_select_out_n_o(ss_n), .serial_clock_out_o(sck),
        .mosi_o(mosi), .miso_i(miso)
    );
    spi_slave_model slave (.sck_i(sck), .ss_n_i(ss_n), .mosi_i(mosi),
        .reply_i(rep), .miso_o(miso), .got_o(got));
    task automatic close_out();
        if (err_total == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    // One falling edge under the wait bound
    task automatic step();
        @(negedge mclk);
        guard++;
        if (guard > 5000)
        begin
            err_total++;
            $display("FAIL %0t wait ran out", $time);
            close_out();
        end
    endtask : step
    // Offer a word and hold it until the holding register takes it
    task automatic put(input logic [7:0] d);
        @(negedge mclk);
        tx_d  = d;
        tx_v  = 1'b1;
        guard = 0;
        while (tx_rdy !== 1'b1)
            step();
        step();
        tx_v = 1'b0;
    endtask : put
    // Run until idle, counting clock activity and the quiet gap
    task automatic drain_bus();
        rises = 0;
        highs = 0;
        gap   = 0;
        while (ss_n !== 1'b0)
            step();
        while (idle !== 1'b1)
        begin
            sck_p = sck;
            step();
            rises += int'(sck & ~sck_p);
            highs += int'(sck);
            gap   += int'(ss_n);
        end
    endtask : drain_bus
    // Check the head received word, pop it, let the flags settle
    task automatic pop(input logic [7:0] e);
        `CHK(rx_v, 1'b1)
        `CHK(rx_d, e)
        rx_r = 1'b1;
        @(negedge mclk);
        rx_r = 1'b0;
        @(negedge mclk);
    endtask : pop
    initial
    begin
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        repeat (2) @(negedge mclk);
        `CHK({txe, idle, rxf}, 3'b110)
        foreach (rows[i])
        begin
            div = rows[i].div;
            dly = rows[i].dly;
            rep = rows[i].rep;
            put(rows[i].tx);
            drain_bus();
            `CHK(rises, 8)
            `CHK(highs, 8 * ((div == 8'h00) ? 1 : int'(div)))
            `CHK(got, rows[i].tx)
            `CHK(gap >= int'(dly), 1'b1)
            `CHK(txe, 1'b1)
            `CHK(rxf, 1'b1)
            pop(rows[i].rep);
            `CHK(rxf, 1'b0)
        end
        // Three words back to back; the third reply overflows
        div = 8'h01;
        dly = 8'h00;
        rep = 8'h5a;
        put(8'h11);
        put(8'h22);
        step();
        `CHK(txe, 1'b0)
        put(8'h33);
        drain_bus();
        `CHK(got, 8'h33)
        pop(8'h5a);
        pop(8'h5a);
        `CHK(rx_v, 1'b0)
        // Disabled block shows no transmit flags
        en    = 1'b0;
        guard = 0;
        step();
        `CHK({txe, idle}, 2'b00)
        en = 1'b1;
        // Memory mode selected: no transfer may start
        mms  = 1'b1;
        tx_d = 8'h77;
        tx_v = 1'b1;
        seen = 1'b0;
        repeat (30)
        begin
            @(negedge mclk);
            seen = seen | ~ss_n;
        end
        `CHK(seen, 1'b0)
        // Reset in mid-run
        rst_n = 1'b0;
        mms   = 1'b0;
        tx_v  = 1'b0;
        repeat (4) @(negedge mclk);
        `CHK({txe, idle, rxf, ss_n, sck, tx_rdy}, 6'b000100)
        rst_n = 1'b1;
        repeat (2) @(negedge mclk);
        `CHK({txe, idle, tx_rdy}, 3'b111)
        close_out();
    end
endmodule : spi_master_legacy_mode_tb
`default_nettype wire
